// ==== hdl/dps_pkg.sv ====
// shared constants and types for the dma parameter set channel
package dps_pkg;
  // parameter memory geometry
  localparam int DPS_WORDS = 8;
  localparam int DPS_NSETS = 4;
  // word index of each field word within a set
  localparam int DPS_W_OPT  = 0;
  localparam int DPS_W_SRC  = 1;
  localparam int DPS_W_CNT  = 2;
  localparam int DPS_W_DST  = 3;
  localparam int DPS_W_BIDX = 4;
  localparam int DPS_W_LINK = 5;
  localparam int DPS_W_CIDX = 6;
  localparam int DPS_W_FCNT = 7;
  // control and status byte addresses
  localparam logic [31:0] DPS_CTRL_ADDR = 32'h0000_0100;
  localparam logic [31:0] DPS_STAT_ADDR = 32'h0000_0104;
  // field positions
  localparam int DPS_SYNC_BIT  = 0;
  localparam int DPS_GO_BIT    = 0;
  localparam int DPS_CLR_BIT   = 1;
  localparam int DPS_ST_BUSY   = 0;
  localparam int DPS_ST_DONE   = 1;
  localparam int DPS_ST_NULL   = 2;
  localparam int DPS_ST_MISS   = 3;
  localparam int DPS_ST_ERR    = 4;
  // values
  localparam logic [15:0] DPS_NULL_LINK = 16'hffff;
  localparam logic [31:0] DPS_WORD_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    DPS_IDLE,
    DPS_ISSUE,
    DPS_LINK
  } dps_state_e;

  // transfer request towards the transfer controller
  typedef struct packed {
    logic        valid;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] bytes;
  } dps_tr_s;
endpackage

// ==== hdl/dps_channel.sv ====
// dma channel: parameter set memory, apb slave and request sequencer
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - The source start word holds the full 32-bit byte address data is read from.
// - The destination start word holds the full 32-bit byte address data is written to.
// - The low half of the count word is the unsigned byte count of one array, nonzero.
// - The high half of the count word is the unsigned number of arrays per frame, nonzero.
// - The low half of the array step word is a signed source step between arrays.
// - The high half of the array step word is a signed destination step between arrays.
// - In array-synchronized mode the array count reloads from the reload half at frame end.
// - An exhausted set is replaced by the set found at the chain pointer address.
// - A chain pointer of all ones means no set follows and nothing is copied.
// - The low half of the frame step word is a signed source step between frames.
// - The high half of the frame step word is a signed destination step between frames.
// - Every parameter word is read/write and must be programmed before use.
// - With sync option 0 each event moves exactly one array.
// - With sync option 1 each event moves a whole frame of arrays.
// - The frame count is an unsigned 16-bit value in the low half of its own word.
module dps_channel
  import dps_pkg::*;
#(
  parameter int N_SETS = DPS_NSETS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger
  input  wire logic        sync_event,
  // transfer request
  output dps_tr_s          tr,
  input  wire logic        tr_ready
);

  localparam int NW = N_SETS * DPS_WORDS;
  localparam int IW = $clog2(NW);
  typedef struct packed {
    dps_state_e           st;
    logic [NW-1:0][31:0]  mem;
    logic [15:0]          arr_left;
    dps_tr_s              tr;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 done;
    logic                 nul;
    logic                 miss;
    logic                 err;
  } dps_q_s;

  dps_q_s      q_reg;
  dps_q_s      q_next;

  logic [31:0] w_src;
  logic [31:0] w_dst;
  logic [15:0] w_first_dim_byte_count;
  logic [15:0] w_array_count;
  logic [15:0] w_sb;
  logic [15:0] w_db;
  logic [15:0] w_link;
  logic [15:0] w_rld;
  logic [15:0] w_sc;
  logic [15:0] w_dc;
  logic [15:0] w_fc;
  logic        sync_ab;
  logic [IW-1:0] lbase;
  logic        lok;
  logic [31:0] lsrc;

  logic        setup;
  logic        acc;
  logic        in_mem;
  logic [IW-1:0] widx;
  logic        go;
  logic        clr;
  logic        ev;
  logic        fend;
  logic [31:0] stat;
  logic        hs;

  // active set is set 0 of the parameter memory
  assign w_src   = q_reg.mem[DPS_W_SRC];
  assign w_dst   = q_reg.mem[DPS_W_DST];
  assign w_first_dim_byte_count  = q_reg.mem[DPS_W_CNT][15:0];
  assign w_array_count  = q_reg.mem[DPS_W_CNT][31:16];
  assign w_sb    = q_reg.mem[DPS_W_BIDX][15:0];
  assign w_db    = q_reg.mem[DPS_W_BIDX][31:16];
  assign w_link  = q_reg.mem[DPS_W_LINK][15:0];
  assign w_rld   = q_reg.mem[DPS_W_LINK][31:16];
  assign w_sc    = q_reg.mem[DPS_W_CIDX][15:0];
  assign w_dc    = q_reg.mem[DPS_W_CIDX][31:16];
  assign w_fc    = q_reg.mem[DPS_W_FCNT][15:0];
  assign sync_ab = q_reg.mem[DPS_W_OPT][DPS_SYNC_BIT];

  // low five pointer bits ignored, set index only
  assign lbase = IW'({w_link[15:5], 3'h0});
  assign lok   = w_link[15:5] < 11'(N_SETS);
  assign lsrc  = q_reg.mem[lbase + IW'(DPS_W_SRC)];
  assign hs = (q_reg.st == DPS_ISSUE) && tr_ready;

  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // sign-extended step, wraps modulo 2^32
  function automatic logic [31:0] step(input logic [31:0] a,
                                       input logic [15:0] d);
    return a + sx(d);
  endfunction

  always_comb begin
    q_next  = q_reg;
    setup   = psel && !penable;
    acc     = psel && penable && q_reg.pready && pwrite && !q_reg.pslverr;
    in_mem  = paddr < 32'(NW * 4);
    widx    = paddr[IW+1:2];
    go      = acc && (paddr == DPS_CTRL_ADDR) && pwdata[DPS_GO_BIT];
    clr     = acc && (paddr == DPS_CTRL_ADDR) && pwdata[DPS_CLR_BIT];
    ev      = sync_event || go;
    fend    = 1'b0;
    stat    = '0;
    stat[DPS_ST_BUSY] = q_reg.st != DPS_IDLE;
    stat[DPS_ST_DONE] = q_reg.done;
    stat[DPS_ST_NULL] = q_reg.nul;
    stat[DPS_ST_MISS] = q_reg.miss;
    stat[DPS_ST_ERR]  = q_reg.err;

    // bus: answer in the first access cycle
    q_next.pready  = setup;
    q_next.pslverr = 1'b0;
    if (setup) begin
      q_next.prdata = '0;
      if (in_mem) begin
        q_next.prdata = q_reg.mem[widx];
      end else if (paddr == DPS_STAT_ADDR) begin
        q_next.prdata = stat;
      end else if (paddr != DPS_CTRL_ADDR) begin
        q_next.pslverr = 1'b1;
      end
    end
    if (acc && in_mem) begin
      q_next.mem[widx] = pwdata;
    end
    // clear first so a same-cycle event still sets
    if (clr) begin
      q_next.done = 1'b0;
      q_next.nul  = 1'b0;
      q_next.miss = 1'b0;
      q_next.err  = 1'b0;
    end

    case (q_reg.st)
      DPS_IDLE: begin
        if (ev) begin
          if (w_first_dim_byte_count == 16'h0 || w_array_count == 16'h0 || w_fc == 16'h0) begin
            q_next.err = 1'b1;
          end else begin
            q_next.arr_left = sync_ab ? w_array_count : 16'h1;
            q_next.tr.valid = 1'b1;
            q_next.tr.src   = w_src;
            q_next.tr.dst   = w_dst;
            q_next.tr.bytes = w_first_dim_byte_count;
            q_next.st       = DPS_ISSUE;
          end
        end
      end
      DPS_ISSUE: begin
        if (ev) begin
          q_next.miss = 1'b1;
        end
        if (tr_ready) begin
          q_next.tr.valid = 1'b0;
          q_next.st       = DPS_IDLE;
          if (sync_ab) begin
            // whole frame per event
            if (q_reg.arr_left != 16'h1) begin
              q_next.arr_left = q_reg.arr_left - 16'h1;
              q_next.tr.valid = 1'b1;
              q_next.tr.src   = step(q_reg.tr.src, w_sb);
              q_next.tr.dst   = step(q_reg.tr.dst, w_db);
              q_next.st       = DPS_ISSUE;
            end else begin
              fend = 1'b1;
            end
          end else if (w_array_count != 16'h1) begin
            // one array per event
            q_next.mem[DPS_W_CNT][31:16] = w_array_count - 16'h1;
            q_next.mem[DPS_W_SRC] = step(w_src, w_sb);
            q_next.mem[DPS_W_DST] = step(w_dst, w_db);
          end else begin
            q_next.mem[DPS_W_CNT][31:16] = w_rld;
            fend = 1'b1;
          end
          if (fend) begin
            q_next.mem[DPS_W_FCNT][15:0] = w_fc - 16'h1;
            q_next.mem[DPS_W_SRC] = step(w_src, w_sc);
            q_next.mem[DPS_W_DST] = step(w_dst, w_dc);
            if (w_fc == 16'h1) begin
              q_next.st = DPS_LINK;
            end
          end
        end
      end
      DPS_LINK: begin
        if (ev) begin
          q_next.miss = 1'b1;
        end
        q_next.st   = DPS_IDLE;
        q_next.done = 1'b1;
        if (w_link == DPS_NULL_LINK) begin
          q_next.nul = 1'b1;
        end else if (!lok) begin
          q_next.err = 1'b1;
        end else begin
          for (int i = 0; i < DPS_WORDS; i++) begin
            q_next.mem[i] = q_reg.mem[lbase + IW'(i)];
          end
        end
      end
      default: begin
        q_next.st = DPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign prdata  = q_reg.prdata;
  assign pready  = q_reg.pready;
  assign pslverr = q_reg.pslverr;
  assign tr      = q_reg.tr;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    ev && q_reg.st == DPS_IDLE && w_first_dim_byte_count != 16'h0
      && w_array_count != 16'h0 && w_fc != 16'h0;
  endsequence
  property p_src_start;
    s_start |=> q_reg.tr.valid && q_reg.tr.src == $past(w_src);
  endproperty
  a_src_start: assert property (p_src_start)
    else $error("request source not the start address");
  property p_dst_start;
    s_start |=> q_reg.tr.dst == $past(w_dst) && q_reg.tr.bytes == $past(w_first_dim_byte_count);
  endproperty
  a_dst_start: assert property (p_dst_start)
    else $error("request destination not the start address");
  property p_zero_first_dim_byte_count;
    ev && q_reg.st == DPS_IDLE && w_first_dim_byte_count == 16'h0 |=> !q_reg.tr.valid && q_reg.err;
  endproperty
  a_zero_first_dim_byte_count: assert property (p_zero_first_dim_byte_count)
    else $error("zero byte count not refused");
  property p_zero_array_count;
    ev && q_reg.st == DPS_IDLE && w_array_count == 16'h0 |=> q_reg.st == DPS_IDLE && q_reg.err;
  endproperty
  a_zero_array_count: assert property (p_zero_array_count)
    else $error("zero array count not refused");
  property p_src_arr;
    hs && !sync_ab && w_array_count != 16'h1 |=> w_src == step($past(w_src), $past(w_sb));
  endproperty
  a_src_arr: assert property (p_src_arr)
    else $error("source array step wrong");
  property p_dst_arr;
    hs && sync_ab && q_reg.arr_left != 16'h1
      |=> q_reg.tr.dst == step($past(q_reg.tr.dst), $past(w_db));
  endproperty
  a_dst_arr: assert property (p_dst_arr)
    else $error("destination array step wrong");
  property p_reload;
    hs && !sync_ab && w_array_count == 16'h1 |=> w_array_count == $past(w_rld);
  endproperty
  a_reload: assert property (p_reload)
    else $error("array count not reloaded");
  property p_link;
    q_reg.st == DPS_LINK && w_link != DPS_NULL_LINK && lok
      |=> q_reg.done && w_src == $past(lsrc);
  endproperty
  a_link: assert property (p_link)
    else $error("chained set not copied");
  property p_null;
    q_reg.st == DPS_LINK && w_link == DPS_NULL_LINK
      |=> q_reg.nul && $stable(w_src) && q_reg.st == DPS_IDLE;
  endproperty
  a_null: assert property (p_null)
    else $error("null chain mishandled");
  property p_frm_src;
    hs && !sync_ab && w_array_count == 16'h1 |=> w_src == step($past(w_src), $past(w_sc));
  endproperty
  a_frm_src: assert property (p_frm_src)
    else $error("source frame step wrong");
  property p_frm_dst;
    hs && !sync_ab && w_array_count == 16'h1 |=> w_dst == step($past(w_dst), $past(w_dc));
  endproperty
  a_frm_dst: assert property (p_frm_dst)
    else $error("destination frame step wrong");
  property p_one_arr;
    hs && !sync_ab |=> !q_reg.tr.valid;
  endproperty
  a_one_arr: assert property (p_one_arr)
    else $error("more than one array per event");
  property p_frame;
    hs && sync_ab && q_reg.arr_left != 16'h1 |=> q_reg.tr.valid;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame cut short");
  property p_fcnt;
    hs && !sync_ab && w_array_count == 16'h1 |=> w_fc == 16'($past(w_fc) - 16'h1);
  endproperty
  a_fcnt: assert property (p_fcnt)
    else $error("frame count not decremented");
  c_ab_frame: cover property (hs && sync_ab ##2 hs);
  c_link:     cover property (q_reg.st == DPS_LINK && lok);
  c_null:     cover property (q_reg.st == DPS_LINK && w_link == DPS_NULL_LINK);
  c_miss:     cover property (q_reg.st != DPS_IDLE && sync_event);

endmodule

`default_nettype wire

// ==== test/dps_tc_model.sv ====
// transfer controller model that accepts requests after a set stall
`timescale 1ns/1ps
`default_nettype none
module dps_tc_model
  import dps_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request side
  input  wire dps_tr_s    tr,
  output logic            tr_ready,
  // cycles to hold off each request
  input  wire logic [3:0] stall
);
  logic [31:0] got_src [16];
  logic [31:0] got_dst [16];
  logic [15:0] got_len [16];
  int          cnt;
  logic [3:0]  wait_cnt;

  // ready only after valid is seen, dropped right after each handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_ready <= 1'b0;
      cnt      <= 0;
      wait_cnt <= 4'h0;
    end else if (tr.valid && tr_ready) begin
      got_src[cnt[3:0]] <= tr.src;
      got_dst[cnt[3:0]] <= tr.dst;
      got_len[cnt[3:0]] <= tr.bytes;
      cnt               <= cnt + 1;
      tr_ready          <= 1'b0;
      wait_cnt          <= 4'h0;
    end else if (tr.valid) begin
      if (wait_cnt >= stall)
        tr_ready <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== test/dps_channel_tb.sv ====
// self-checking bench for the parameter set channel
`timescale 1ns/1ps
`default_nettype none
module dps_channel_tb
  import dps_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_event = 1'b0;
  dps_tr_s     tr;
  logic        tr_ready;
  logic [3:0]  stall = 4'h0;
  int          bad_count = 0;
  int          num_checks = 0;

  always #12.5 pclk = ~pclk;

  dps_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_event(sync_event), .tr(tr), .tr_ready(tr_ready));
  dps_tc_model tcm (.pclk(pclk), .presetn(presetn), .tr(tr), .tr_ready(tr_ready),
    .stall(stall));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  task automatic wait_n(input int n);
    int k;
    for (k = 0; k < 200 && tcm.cnt != n; k++)
      @(posedge pclk);
    if (tcm.cnt != n) begin
      bad_count++;
      give_verdict();
    end
    repeat (2) @(posedge pclk);
  endtask

  task automatic exp_tr(input int i, input logic [31:0] s, input logic [31:0] d,
                        input logic [15:0] b);
    chk("tr src", s, tcm.got_src[i]);
    chk("tr dst", d, tcm.got_dst[i]);
    chk("tr bytes", {16'h0, b}, {16'h0, tcm.got_len[i]});
  endtask

  task automatic load_set(input logic [31:0] base, input logic [31:0] w [8]);
    for (int i = 0; i < 8; i++)
      wr(base + 32'(i * 4), w[i]);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 8; i++)
      wr(32'h40 + 32'(i * 4), 32'h9e37_79b9 * 32'(i + 1));
    for (int i = 0; i < 8; i++)
      rd("set word", 32'h40 + 32'(i * 4), 32'h9e37_79b9 * 32'(i + 1));
    apb(1'b0, 32'h200, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask

  task automatic t_sync0;
    logic [31:0] es [4] = '{32'hffff_fffc, 32'h4, 32'h104, 32'h10c};
    logic [31:0] ed [4] = '{32'h2000, 32'h1ff8, 32'h1ef8, 32'h1ef0};
    stall <= 4'h3;
    load_set(32'h0, '{32'h0, 32'hffff_fffc, 32'h0002_0010, 32'h2000, 32'hfff8_0008,
             32'h0002_ffff, 32'hff00_0100, 32'h2});
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      sync_event <= 1'b1;
      // last event held a second cycle, which lands while busy
      repeat ((i == 3) ? 2 : 1) @(posedge pclk);
      sync_event <= 1'b0;
      wait_n(i + 1);
      exp_tr(i, es[i], ed[i], 16'h10);
      if (i == 1) begin
        rd("count word", 32'h8, 32'h0002_0010);
        rd("frame count", 32'h1c, 32'h1);
      end
    end
    rd("status", DPS_STAT_ADDR, 32'he);
  endtask

  task automatic t_zero;
    wr(DPS_CTRL_ADDR, 32'h2);
    rd("status clear", DPS_STAT_ADDR, 32'h0);
    // frame count left at zero by the last run; make it valid
    wr(32'h1c, 32'h1);
    wr(32'h8, 32'h0001_0000);
    wr(DPS_CTRL_ADDR, 32'h1);
    rd("status zero", DPS_STAT_ADDR, 32'h10);
    wr(DPS_CTRL_ADDR, 32'h2);
    wr(32'h8, 32'h0000_0010);
    @(posedge pclk);
    sync_event <= 1'b1;
    @(posedge pclk);
    sync_event <= 1'b0;
    rd("status zero arrays", DPS_STAT_ADDR, 32'h10);
    chk("no request", 32'h4, 32'(tcm.cnt));
  endtask

  task automatic t_sync1;
    wr(DPS_CTRL_ADDR, 32'h2);
    stall <= 4'h0;
    load_set(32'h20, '{32'h0, 32'h8000_0000, 32'h0001_0004, 32'h9000_0000, 32'h0,
             32'h0000_ffff, 32'h0, 32'h1});
    load_set(32'h0, '{32'h1, 32'h3000, 32'h0003_0008, 32'h4000, 32'h0020_0010,
             32'h0000_0020, 32'h0, 32'h1});
    wr(DPS_CTRL_ADDR, 32'h1);
    wait_n(7);
    for (int i = 0; i < 3; i++)
      exp_tr(4 + i, 32'h3000 + 32'(i * 16), 32'h4000 + 32'(i * 32), 16'h8);
    rd("linked src", 32'h4, 32'h8000_0000);
    rd("linked dst", 32'hc, 32'h9000_0000);
    rd("linked count", 32'h8, 32'h0001_0004);
    rd("status link", DPS_STAT_ADDR, 32'h2);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sync0();
    t_zero();
    t_sync1();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
